// [core/gpio_pad_drive.v]
/*
 * Per-pin source selection and drive mode decode into registered pad controls.
 * Assumes the pad cell resolves a driven level, weak pulls and analog switch from these controls.
 */
`timescale 1ns/1ps
`include "gpio_defs.vh"

module gpio_pad_drive (
	// Clock and reset
	input  wire                      sys_clk,
	input  wire                      reset_n,
	// Configuration
	input  wire                      hold,
	input  wire [`GPIO_FIELD_W-1:0]  mode,
	input  wire [`GPIO_FIELD_W-1:0]  src,
	input  wire [`GPIO_PINS-1:0]     lvttl,
	input  wire [`GPIO_PINS-1:0]     slow,
	// Data sources
	input  wire [`GPIO_PINS-1:0]     port_data,
	input  wire [`GPIO_PINS-1:0]     periph0,
	input  wire [`GPIO_PINS-1:0]     periph1,
	input  wire [`GPIO_PINS-1:0]     periph2,
	// Pad controls
	output reg  [`GPIO_PINS-1:0]     pad_out_q,
	output reg  [`GPIO_PINS-1:0]     pad_oe_n_q,
	output reg  [`GPIO_PINS-1:0]     pad_pull_up_q,
	output reg  [`GPIO_PINS-1:0]     pad_pull_dn_q,
	output reg  [`GPIO_PINS-1:0]     pad_in_en_q,
	output reg  [`GPIO_PINS-1:0]     pad_analog_q,
	output reg  [`GPIO_PINS-1:0]     pad_lvttl_q,
	output reg  [`GPIO_PINS-1:0]     pad_slow_q
);

	reg [`GPIO_PINS-1:0]   out_d;
	reg [`GPIO_PINS-1:0]   oe_n_d;
	reg [`GPIO_PINS-1:0]   pu_d;
	reg [`GPIO_PINS-1:0]   pd_d;
	reg [`GPIO_PINS-1:0]   in_en_d;
	reg [`GPIO_PINS-1:0]   ana_d;
	reg [`GPIO_MODE_W-1:0] m;
	reg                    v;
	integer                i;

	always @*
	begin
		out_d   = `GPIO_RST_BYTE;
		oe_n_d  = ~`GPIO_RST_BYTE;
		pu_d    = `GPIO_RST_BYTE;
		pd_d    = `GPIO_RST_BYTE;
		in_en_d = `GPIO_RST_BYTE;
		ana_d   = `GPIO_RST_BYTE;
		m       = `GPIO_DM_ANALOG;
		v       = 1'b0;
		for (i = 0; i < `GPIO_PINS; i = i + 1)
		begin
			m = mode[i*`GPIO_MODE_W +: `GPIO_MODE_W];
			case (src[i*`GPIO_SRC_W +: `GPIO_SRC_W])
				`GPIO_SRC_PORT:    v = port_data[i];
				`GPIO_SRC_PERIPH0: v = periph0[i];
				`GPIO_SRC_PERIPH1: v = periph1[i];
				`GPIO_SRC_PERIPH2: v = periph2[i];
				default:           v = 1'b0;
			endcase
			ana_d[i] = (src[i*`GPIO_SRC_W +: `GPIO_SRC_W] == `GPIO_SRC_ANALOG);
			out_d[i] = v;
			in_en_d[i] = (m != `GPIO_DM_ANALOG);
			// Strong drivers switch only toward the rails that the mode allows.
			case (m)
				`GPIO_DM_STRONG:                  oe_n_d[i] = 1'b0;
				`GPIO_DM_WPU_SPD, `GPIO_DM_OD_SPD: oe_n_d[i] = v;
				`GPIO_DM_SPU_WPD, `GPIO_DM_OD_SPU: oe_n_d[i] = ~v;
				default:                          oe_n_d[i] = 1'b1;
			endcase
			pu_d[i] = v & ((m == `GPIO_DM_WPU_SPD) | (m == `GPIO_DM_WPU_WPD));
			pd_d[i] = ~v & ((m == `GPIO_DM_SPU_WPD) | (m == `GPIO_DM_WPU_WPD));
		end
	end

	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			// Analog with both buffers off, so no input is crowbarred at power-up.
			pad_out_q     <= `GPIO_RST_BYTE;
			pad_oe_n_q    <= ~`GPIO_RST_BYTE;
			pad_pull_up_q <= `GPIO_RST_BYTE;
			pad_pull_dn_q <= `GPIO_RST_BYTE;
			pad_in_en_q   <= `GPIO_RST_BYTE;
			pad_analog_q  <= `GPIO_RST_BYTE;
			pad_lvttl_q   <= `GPIO_RST_BYTE;
			pad_slow_q    <= `GPIO_RST_BYTE;
		end
		else if (!hold)
		begin
			pad_out_q     <= out_d;
			pad_oe_n_q    <= oe_n_d;
			pad_pull_up_q <= pu_d;
			pad_pull_dn_q <= pd_d;
			pad_in_en_q   <= in_en_d;
			pad_analog_q  <= ana_d;
			pad_lvttl_q   <= lvttl;
			pad_slow_q    <= slow;
		end
	end

endmodule // gpio_pad_drive

// [core/gpio_pin_sync.v]
/*
 * Two-stage synchroniser for the eight pin input levels.
 * Assumes the pin levels are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "gpio_defs.vh"

module gpio_pin_sync (
	// Clock and reset
	input  wire                    sys_clk,
	input  wire                    reset_n,
	// Pin levels
	input  wire [`GPIO_PINS-1:0]   pin_in,
	output reg  [`GPIO_PINS-1:0]   pin_sync_q
);

	reg [`GPIO_PINS-1:0] meta_q;

	// Only the second stage is read outside this module.
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			meta_q     <= `GPIO_RST_BYTE;
			pin_sync_q <= `GPIO_RST_BYTE;
		end
		else
		begin
			meta_q     <= pin_in;
			pin_sync_q <= meta_q;
		end
	end

endmodule // gpio_pin_sync

// [core/gpio_port_control.v]
/*
 * One general-purpose I/O port of eight pins with its AXI4-Lite register slave,
 * per-pin interrupt flags gathered into one request, and registered pad controls.
 * Assumes an AXI4-Lite master on sys_clk and pads that take the pad_* controls.
 */
`timescale 1ns/1ps
`include "gpio_defs.vh"

module gpio_port_control (
	// Clock and reset
	input  wire                     sys_clk,
	input  wire                     reset_n,
	// AXI4-Lite write address
	input  wire [`GPIO_ADDR_W-1:0]  s_axi_awaddr,
	input  wire                     s_axi_awvalid,
	output reg                      s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]              s_axi_wdata,
	input  wire [3:0]               s_axi_wstrb,
	input  wire                     s_axi_wvalid,
	output reg                      s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]               s_axi_bresp,
	output reg                      s_axi_bvalid,
	input  wire                     s_axi_bready,
	// AXI4-Lite read address
	input  wire [`GPIO_ADDR_W-1:0]  s_axi_araddr,
	input  wire                     s_axi_arvalid,
	output reg                      s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]              s_axi_rdata,
	output reg  [1:0]               s_axi_rresp,
	output reg                      s_axi_rvalid,
	input  wire                     s_axi_rready,
	// Peripheral connections through the pin source matrix
	input  wire [`GPIO_PINS-1:0]    periph0_out,
	input  wire [`GPIO_PINS-1:0]    periph1_out,
	input  wire [`GPIO_PINS-1:0]    periph2_out,
	output reg  [`GPIO_PINS-1:0]    periph_in_q,
	// Port interrupt request
	output reg                      port_irq_q,
	// Pads
	input  wire [`GPIO_PINS-1:0]    pad_in,
	output wire [`GPIO_PINS-1:0]    pad_out,
	output wire [`GPIO_PINS-1:0]    pad_oe_n,
	output wire [`GPIO_PINS-1:0]    pad_pull_up,
	output wire [`GPIO_PINS-1:0]    pad_pull_dn,
	output wire [`GPIO_PINS-1:0]    pad_in_en,
	output wire [`GPIO_PINS-1:0]    pad_analog,
	output wire [`GPIO_PINS-1:0]    pad_lvttl,
	output wire [`GPIO_PINS-1:0]    pad_slow
);

	// Registers.
	reg  [`GPIO_PINS-1:0]    out_data_q;
	reg  [`GPIO_PINS-1:0]    int_en_q;
	reg  [`GPIO_PINS-1:0]    int_st_q;
	reg  [`GPIO_PINS-1:0]    int_st_d;
	reg  [`GPIO_FIELD_W-1:0] drive_mode_q;
	reg  [`GPIO_FIELD_W-1:0] pin_src_q;
	reg  [`GPIO_PINS-1:0]    lvttl_q;
	reg  [`GPIO_PINS-1:0]    slow_q;
	reg                      hold_q;

	// Bus capture state.
	reg                      aw_got_q;
	reg                      w_got_q;
	reg  [`GPIO_ADDR_W-1:0]  waddr_q;
	reg  [31:0]              wdata_q;
	reg  [3:0]               wstrb_q;

	// Input sampling and write decode.
	wire [`GPIO_PINS-1:0]    pin_state;
	reg  [`GPIO_PINS-1:0]    pin_prev_q;
	wire [`GPIO_PINS-1:0]    pin_edge;
	wire                     do_write;
	wire [31:0]              wmask;

	// Merged write words; only the low bits of each belong to its register.
	wire [31:0]              out_word;
	wire [31:0]              mode_word;
	wire [31:0]              src_word;

	// Expands byte strobes into a bit mask.
	function [31:0] strb_mask;
		input [3:0] strb;
		begin
			strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		end
	endfunction

	// Merges strobed write data into an old register word.
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [31:0] mask;
		begin
			merge = (old & ~mask) | (data & mask);
		end
	endfunction

	// Tells whether a byte offset names one of the port registers.
	function mapped;
		input [`GPIO_ADDR_W-1:0] a;
		begin
			case (a)
				`GPIO_OFS_OUT, `GPIO_OFS_STATE, `GPIO_OFS_INT_EN, `GPIO_OFS_INT_ST,
				`GPIO_OFS_MODE, `GPIO_OFS_PADCFG, `GPIO_OFS_SRC, `GPIO_OFS_HOLD:
					mapped = 1'b1;
				default:
					mapped = 1'b0;
			endcase
		end
	endfunction

	gpio_pin_sync u_sync (
		.sys_clk    (sys_clk),
		.reset_n    (reset_n),
		.pin_in     (pad_in),
		.pin_sync_q (pin_state)
	);

	gpio_pad_drive u_drive (
		.sys_clk       (sys_clk),
		.reset_n       (reset_n),
		.hold          (hold_q),
		.mode          (drive_mode_q),
		.src           (pin_src_q),
		.lvttl         (lvttl_q),
		.slow          (slow_q),
		.port_data     (out_data_q),
		.periph0       (periph0_out),
		.periph1       (periph1_out),
		.periph2       (periph2_out),
		.pad_out_q     (pad_out),
		.pad_oe_n_q    (pad_oe_n),
		.pad_pull_up_q (pad_pull_up),
		.pad_pull_dn_q (pad_pull_dn),
		.pad_in_en_q   (pad_in_en),
		.pad_analog_q  (pad_analog),
		.pad_lvttl_q   (pad_lvttl),
		.pad_slow_q    (pad_slow)
	);

	assign do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
	assign wmask    = strb_mask(wstrb_q);
	assign pin_edge = pin_state ^ pin_prev_q;

	assign out_word  = merge({24'h000000, out_data_q}, wdata_q, wmask);
	assign mode_word = merge({8'h00, drive_mode_q}, wdata_q, wmask);
	assign src_word  = merge({8'h00, pin_src_q}, wdata_q, wmask);

	// Any level change on an enabled pin sets its flag; a set in the clearing cycle wins.
	always @*
	begin
		int_st_d = int_st_q;
		if (do_write && (waddr_q == `GPIO_OFS_INT_ST))
			int_st_d = int_st_q & ~(wdata_q[`GPIO_PINS-1:0] & wmask[`GPIO_PINS-1:0]);
		int_st_d = int_st_d | (pin_edge & int_en_q);
	end

	// Write channels: address and data are taken in either order, one write at a time.
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `GPIO_RESP_OKAY;
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			waddr_q       <= `GPIO_RST_BYTE;
			wdata_q       <= `GPIO_RST_WORD;
			wstrb_q       <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_q      <= 1'b1;
				waddr_q       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_q      <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(waddr_q) ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Register file. Writes to the pin state offset are accepted and have no effect.
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			out_data_q   <= `GPIO_RST_BYTE;
			int_en_q     <= `GPIO_RST_BYTE;
			int_st_q     <= `GPIO_RST_BYTE;
			drive_mode_q <= `GPIO_RST_FIELD;
			pin_src_q    <= `GPIO_RST_FIELD;
			lvttl_q      <= `GPIO_RST_BYTE;
			slow_q       <= `GPIO_RST_BYTE;
			hold_q       <= 1'b0;
			pin_prev_q   <= `GPIO_RST_BYTE;
			periph_in_q  <= `GPIO_RST_BYTE;
			port_irq_q   <= 1'b0;
		end
		else
		begin
			int_st_q    <= int_st_d;
			pin_prev_q  <= pin_state;
			periph_in_q <= pin_state;
			port_irq_q  <= |(int_st_d & int_en_q);
			if (do_write)
			begin
				case (waddr_q)
					`GPIO_OFS_OUT:
						out_data_q <= out_word[`GPIO_PINS-1:0];
					`GPIO_OFS_INT_EN:
						int_en_q <= wdata_q[`GPIO_PINS-1:0] & wmask[`GPIO_PINS-1:0] |
							int_en_q & ~wmask[`GPIO_PINS-1:0];
					`GPIO_OFS_MODE:
						drive_mode_q <= mode_word[`GPIO_FIELD_W-1:0];
					`GPIO_OFS_PADCFG:
					begin
						if (wstrb_q[0])
							lvttl_q <= wdata_q[`GPIO_CFG_LVTTL_LSB +: `GPIO_PINS];
						if (wstrb_q[1])
							slow_q <= wdata_q[`GPIO_CFG_SLOW_LSB +: `GPIO_PINS];
					end
					`GPIO_OFS_SRC:
						pin_src_q <= src_word[`GPIO_FIELD_W-1:0];
					`GPIO_OFS_HOLD:
						if (wstrb_q[0])
							hold_q <= wdata_q[0];
					default:
						hold_q <= hold_q;
				endcase
			end
		end
	end

	// Read channel: the data follows one cycle after the address is taken.
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= `GPIO_RST_WORD;
			s_axi_rresp   <= `GPIO_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= mapped(s_axi_araddr) ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
			case (s_axi_araddr)
				`GPIO_OFS_OUT:    s_axi_rdata <= {24'h000000, out_data_q};
				`GPIO_OFS_STATE:  s_axi_rdata <= {24'h000000, pin_state};
				`GPIO_OFS_INT_EN: s_axi_rdata <= {24'h000000, int_en_q};
				`GPIO_OFS_INT_ST: s_axi_rdata <= {24'h000000, int_st_q};
				`GPIO_OFS_MODE:   s_axi_rdata <= {8'h00, drive_mode_q};
				`GPIO_OFS_PADCFG: s_axi_rdata <= {16'h0000, slow_q, lvttl_q};
				`GPIO_OFS_SRC:    s_axi_rdata <= {8'h00, pin_src_q};
				`GPIO_OFS_HOLD:   s_axi_rdata <= {31'h00000000, hold_q};
				default:          s_axi_rdata <= `GPIO_RST_WORD;
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // gpio_port_control

// [shared/gpio_defs.vh]
/*
 * Constants for the general-purpose I/O port: register byte offsets, reset values,
 * drive mode codes, pin source codes and bus response codes.
 * Assumes it is included by bare name into the port design files and the testbench.
 */
`ifndef GPIO_DEFS_VH
`define GPIO_DEFS_VH

// Port geometry.
`define GPIO_PINS        8
`define GPIO_ADDR_W      8
`define GPIO_MODE_W      3
`define GPIO_SRC_W       3
`define GPIO_FIELD_W     24

// Register byte offsets.
`define GPIO_OFS_OUT     8'h00
`define GPIO_OFS_STATE   8'h04
`define GPIO_OFS_INT_EN  8'h08
`define GPIO_OFS_INT_ST  8'h0c
`define GPIO_OFS_MODE    8'h10
`define GPIO_OFS_PADCFG  8'h14
`define GPIO_OFS_SRC     8'h18
`define GPIO_OFS_HOLD    8'h1c

// Reset values.
`define GPIO_RST_BYTE    8'h00
`define GPIO_RST_FIELD   24'h000000
`define GPIO_RST_WORD    32'h00000000

// Drive modes, in the documented order.
`define GPIO_DM_ANALOG   3'h0
`define GPIO_DM_INPUT    3'h1
`define GPIO_DM_WPU_SPD  3'h2
`define GPIO_DM_SPU_WPD  3'h3
`define GPIO_DM_OD_SPD   3'h4
`define GPIO_DM_OD_SPU   3'h5
`define GPIO_DM_STRONG   3'h6
`define GPIO_DM_WPU_WPD  3'h7

// Pin source selections.
`define GPIO_SRC_PORT    3'h0
`define GPIO_SRC_PERIPH0 3'h1
`define GPIO_SRC_PERIPH1 3'h2
`define GPIO_SRC_PERIPH2 3'h3
`define GPIO_SRC_ANALOG  3'h4

// Pad configuration field positions.
`define GPIO_CFG_LVTTL_LSB 0
`define GPIO_CFG_SLOW_LSB  8

// Bus responses.
`define GPIO_RESP_OKAY   2'h0
`define GPIO_RESP_SLVERR 2'h2

`endif

// [verif/gpio_ext_pins.sv]
/* Board model of the devices wired to the eight port pins.
   Assumes one port's pad controls; a board pull-down holds a released pin low. */
`timescale 1ns/1ps
module gpio_ext_pins (
	// Pad controls
	input  wire [7:0] pad_out,
	input  wire [7:0] pad_oe_n,
	input  wire [7:0] pad_pull_up,
	// External drivers
	input  wire [7:0] ext_en,
	input  wire [7:0] ext_val,
	// Pin level
	output wire [7:0] pad_in
);
	// An outside driver wins over the port; a weak pull-up beats only the board pull-down.
	assign pad_in = (ext_en & ext_val) | (~ext_en & ~pad_oe_n & pad_out) | (~ext_en & pad_oe_n & pad_pull_up);
endmodule // gpio_ext_pins

// [verif/gpio_port_chk.sv]
/* Checker for the I/O port: bus handshakes, reset pad state, input sync and pad decode.
   Assumes it is bound to gpio_port_control and sees only that module's ports. */
`timescale 1ns/1ps
module gpio_port_chk (
	// Clock and reset
	input wire        sys_clk,
	input wire        reset_n,
	// Bus handshakes
	input wire        s_axi_awready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// Pins
	input wire [7:0]  pad_in,
	input wire [7:0]  periph_in_q,
	input wire [7:0]  pad_out,
	input wire [7:0]  pad_oe_n,
	input wire [7:0]  pad_in_en,
	input wire [7:0]  pad_analog
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	aw_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken while response pending");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");
	rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	reset_pads_a: assert property (!$past(reset_n) |-> pad_oe_n == 8'hff && pad_in_en == 8'h00
		&& pad_analog == 8'h00)
		else $error("pads not analog after reset");
	sync_delay_a: assert property ($past(reset_n, 3) && $past(reset_n, 2) && $past(reset_n)
		|-> periph_in_q == $past(pad_in, 3))
		else $error("pin level not seen three cycles later");
	oe_needs_in_a: assert property ((~pad_oe_n & ~pad_in_en) == 8'h00)
		else $error("strong drive in a mode without input buffer");
	analog_zero_a: assert property ((pad_analog & pad_out) == 8'h00)
		else $error("analog source drives a level");

	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($rose(pad_analog[0]));
endmodule // gpio_port_chk

bind gpio_port_control gpio_port_chk chk (
	.sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .pad_in(pad_in), .periph_in_q(periph_in_q), .pad_out(pad_out),
	.pad_oe_n(pad_oe_n), .pad_in_en(pad_in_en), .pad_analog(pad_analog)
);

// [verif/tb.sv]
/* Self-checking bench for the I/O port: bus tasks and scenarios in sequence.
   Assumes gpio_defs.vh on the include path and the board model on the pins. */
`timescale 1ns/1ps
`include "gpio_defs.vh"
module tb;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, p0 = 8'h11, p1 = 8'h22, p2 = 8'h44;
	logic [7:0]  ext_en = 8'h00, ext_val = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire         awrdy, wrdy, bvld, arrdy, rvld, irq;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [7:0]  pin, pin_q, pout, poe_n, ppu, ppd, pien, pana, plv, pslw;
	int          err_total = 0;
	int          checks_done = 0;
	int          m;
	logic [7:0]  s;
	logic [4:0]  t;
	logic [4:0]  dm_tab [8] = '{5'h00, 5'h01, 5'h0d, 5'h13, 5'h09, 5'h11, 5'h19, 5'h07};
	logic [7:0]  src_tab [5] = '{8'h88, 8'h11, 8'h22, 8'h44, 8'h00};

	gpio_port_control DUT (
		.sys_clk(sys_clk), .reset_n(reset_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awrdy),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvld), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arrdy),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvld), .s_axi_rready(rready),
		.periph0_out(p0), .periph1_out(p1), .periph2_out(p2), .periph_in_q(pin_q),
		.port_irq_q(irq), .pad_in(pin), .pad_out(pout), .pad_oe_n(poe_n), .pad_pull_up(ppu),
		.pad_pull_dn(ppd), .pad_in_en(pien), .pad_analog(pana), .pad_lvttl(plv), .pad_slow(pslw)
	);

	gpio_ext_pins board (
		.pad_out(pout), .pad_oe_n(poe_n), .pad_pull_up(ppu), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pin)
	);

	initial forever #2.5 sys_clk = ~sys_clk;

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// Each bus task waits one edge first, so back-to-back calls never drive a signal twice in a step.
	// Waits have no timeout; only the watchdog ends a hung wait, so a hung handshake can never slip through to a pass.
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b, input logic [1:0] r);
		@(posedge sys_clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= b;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (awrdy === 1'b1)
				awvalid <= 1'b0;
			if (wrdy === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvld !== 1'b1);
		bready <= 1'b0;
		chk("bresp", 32'(r), 32'(bresp));
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge sys_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (arrdy === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvld !== 1'b1);
		rready <= 1'b0;
		chk("rdata", e, rdata);
		chk("rresp", 32'(r), 32'(rresp));
	endtask

	task close_out;
		$display("Checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		#100000;
		err_total++;
		close_out;
	end

	initial
	begin
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		chk("oe_n", 32'hff, 32'(poe_n));
		chk("in_en", 32'h0, 32'(pien | pana | ppu | ppd));
		for (m = 0; m < 32; m += 4)
			rd(8'(m), 32'h0, `GPIO_RESP_OKAY);
		$display("reset values done");
		wr(`GPIO_OFS_MODE, 32'h249249, 4'hf, `GPIO_RESP_OKAY);
		wr(`GPIO_OFS_INT_EN, 32'h01, 4'hf, `GPIO_RESP_OKAY);
		ext_en  <= 8'hff;
		ext_val <= 8'h02;
		repeat (6) @(posedge sys_clk);
		chk("irq off", 32'h0, 32'(irq));
		rd(`GPIO_OFS_INT_ST, 32'h0, `GPIO_RESP_OKAY);
		ext_val <= 8'h03;
		repeat (6) @(posedge sys_clk);
		chk("irq on", 32'h1, 32'(irq));
		rd(`GPIO_OFS_STATE, 32'h03, `GPIO_RESP_OKAY);
		chk("periph in", 32'h03, 32'(pin_q));
		rd(`GPIO_OFS_INT_ST, 32'h01, `GPIO_RESP_OKAY);
		wr(`GPIO_OFS_INT_ST, 32'h01, 4'hf, `GPIO_RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		chk("irq clr", 32'h0, 32'(irq));
		ext_en <= 8'h00;
		$display("interrupt test done");
		wr(`GPIO_OFS_OUT, 32'h0f, 4'hf, `GPIO_RESP_OKAY);
		for (m = 0; m < 8; m++)
		begin
			t = dm_tab[m];
			s = ({8{t[4]}} & 8'h0f) | ({8{t[3]}} & 8'hf0);
			wr(`GPIO_OFS_MODE, m * 32'h249249, 4'hf, `GPIO_RESP_OKAY);
			repeat (3) @(posedge sys_clk);
			chk("oe_n", 32'(8'hff ^ s), 32'(poe_n));
			chk("pull_up", 32'({8{t[2]}} & 8'h0f), 32'(ppu & 8'h0f));
			chk("pull_dn", 32'({8{t[1]}} & 8'hf0), 32'(ppd & 8'hf0));
			chk("in_en", 32'({8{t[0]}}), 32'(pien));
		end
		$display("drive mode test done");
		wr(`GPIO_OFS_PADCFG, 32'h5a3c, 4'hf, `GPIO_RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		chk("lvttl", 32'h3c, 32'(plv));
		chk("slow", 32'h5a, 32'(pslw));
		wr(`GPIO_OFS_PADCFG, 32'hff00, 4'h2, `GPIO_RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		chk("lane lvttl", 32'h3c, 32'(plv));
		chk("lane slow", 32'hff, 32'(pslw));
		$display("pad config test done");
		wr(`GPIO_OFS_OUT, 32'h88, 4'hf, `GPIO_RESP_OKAY);
		wr(`GPIO_OFS_MODE, 32'hdb6db6, 4'hf, `GPIO_RESP_OKAY);
		for (m = 0; m < 5; m++)
		begin
			wr(`GPIO_OFS_SRC, m * 32'h249249, 4'hf, `GPIO_RESP_OKAY);
			repeat (3) @(posedge sys_clk);
			chk("src out", 32'(src_tab[m]), 32'(pout));
			chk("analog", (m == 4) ? 32'hff : 32'h0, 32'(pana));
		end
		wr(`GPIO_OFS_SRC, 32'h0, 4'hf, `GPIO_RESP_OKAY);
		// The new pad level needs the pad register and both synchroniser stages before it reads back.
		repeat (3) @(posedge sys_clk);
		rd(`GPIO_OFS_STATE, 32'h88, `GPIO_RESP_OKAY);
		$display("source matrix test done");
		wr(`GPIO_OFS_HOLD, 32'h1, 4'hf, `GPIO_RESP_OKAY);
		wr(`GPIO_OFS_OUT, 32'h3c, 4'hf, `GPIO_RESP_OKAY);
		wr(`GPIO_OFS_MODE, 32'h0, 4'hf, `GPIO_RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		chk("held out", 32'h88, 32'(pout));
		chk("held oe_n", 32'h0, 32'(poe_n));
		wr(`GPIO_OFS_MODE, 32'hdb6db6, 4'hf, `GPIO_RESP_OKAY);
		wr(`GPIO_OFS_HOLD, 32'h0, 4'hf, `GPIO_RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		chk("released out", 32'h3c, 32'(pout));
		wr(`GPIO_OFS_HOLD, 32'h1, 4'hf, `GPIO_RESP_OKAY);
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		chk("reset oe_n", 32'hff, 32'(poe_n));
		chk("reset in_en", 32'h0, 32'(pien | pana));
		rd(`GPIO_OFS_MODE, 32'h0, `GPIO_RESP_OKAY);
		rd(`GPIO_OFS_HOLD, 32'h0, `GPIO_RESP_OKAY);
		$display("hold and reset test done");
		rd(8'h20, 32'h0, `GPIO_RESP_SLVERR);
		wr(8'h20, 32'h1, 4'hf, `GPIO_RESP_SLVERR);
		wr(`GPIO_OFS_STATE, 32'hff, 4'hf, `GPIO_RESP_OKAY);
		rd(`GPIO_OFS_STATE, 32'h0, `GPIO_RESP_OKAY);
		$display("address map test done");
		close_out;
	end
endmodule // tb
